// File: hdl/odt_cycle_cnt.v
/*
 * Execution clock counter: loads a clock count, counts it down on
 * every cycle that is not stalled, and flags the last counted cycle.
 * Assumes load only arrives while the counter is idle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "odt_map.vh"

module odt_cycle_cnt (
  // clock and reset
  input  wire                    ref_clk,
  input  wire                    srst,
  // control
  input  wire                    load,
  input  wire [`ODT_CNT_W-1:0]   load_cnt,
  input  wire                    stall,
  // status
  output reg                     busy_ff,
  output reg                     last_cycle
);

  reg  [`ODT_CNT_W-1:0] cnt_ff;
  reg  [`ODT_CNT_W-1:0] nxt_cnt;
  reg                   nxt_busy;

  // countdown; a stalled cycle is simply not counted.  last_cycle is
  // left unregistered so the caller's done and ready flops rise on the
  // edge that ends the count, not one clock after it
  always @* begin
    nxt_cnt    = cnt_ff;
    nxt_busy   = busy_ff;
    last_cycle = 1'b0;
    if (load) begin
      nxt_cnt  = load_cnt;
      nxt_busy = 1'b1;
    end else if (busy_ff && !stall) begin
      nxt_cnt = cnt_ff - {{(`ODT_CNT_W-1){1'b0}}, 1'b1};
      if (cnt_ff == {{(`ODT_CNT_W-1){1'b0}}, 1'b1}) begin
        nxt_busy   = 1'b0;
        last_cycle = 1'b1;
      end
    end
  end

  // state registers
  always @(posedge ref_clk) begin
    if (srst) begin
      cnt_ff  <= {`ODT_CNT_W{1'b0}};
      busy_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

endmodule // odt_cycle_cnt
`default_nettype wire

// File: hdl/odt_decode.v
/*
 * Opcode decode and timing slice: classifies one instruction handed
 * over by fetch, reports operand, immediate and displacement widths,
 * and holds the instruction for its clock count before taking another.
 * Assumes fetch and execution run on ref_clk; no pin synchronisers.
 */
`timescale 1ns/1ps
`default_nettype none
`include "odt_map.vh"

module odt_decode (
  // clock and reset
  input  wire                    ref_clk,
  input  wire                    srst,
  // instruction from fetch
  input  wire                    fetch_valid,
  input  wire [7:0]              fetch_byte0,
  input  wire [7:0]              fetch_byte1,
  input  wire [7:0]              fetch_byte2,
  input  wire                    op_size_32,
  input  wire                    addr_size_32,
  input  wire [1:0]              imm_form,
  output reg                     fetch_ready_ff,
  // execution side
  input  wire                    mem_stall,
  output reg                     dec_valid_ff,
  output reg  [2:0]              dec_class_ff,
  output reg                     dec_illegal_ff,
  output reg  [1:0]              dec_opnd_w_ff,
  output reg  [1:0]              dec_imm_w_ff,
  output reg  [1:0]              dec_disp_w_ff,
  output reg                     dec_sign_ext_ff,
  output reg                     dec_flags_mod_ff,
  output reg  [`ODT_CNT_W-1:0]   dec_cycles_ff,
  output reg                     exec_done_ff
);

  // ----------------------------------------------------------------
  // byte fields
  // ----------------------------------------------------------------
  wire       is_esc;
  wire       wide_bit;
  wire [7:0] grp_modrm;
  wire [7:0] esc_modrm;
  wire       accept;
  wire       cnt_done;

  assign is_esc    = (fetch_byte0 == `ODT_ESC_BYTE);
  // the w bit sits in the opcode byte, first byte after the escape
  assign wide_bit  = is_esc ? fetch_byte1[0] : fetch_byte0[0];
  assign grp_modrm = fetch_byte1;
  assign esc_modrm = fetch_byte2;
  assign accept    = fetch_valid & fetch_ready_ff;

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  reg  [2:0]            nxt_class;
  reg  [7:0]            modrm;
  reg                   has_modrm;
  reg                   uses_w;

  always @* begin
    nxt_class = `ODT_CL_UNKNOWN;
    modrm     = 8'h00;
    has_modrm = 1'b0;
    uses_w    = 1'b0;
    if (is_esc) begin
      modrm     = esc_modrm;
      has_modrm = 1'b1;
      if (fetch_byte1[7:1] == `ODT_MSX_HI7) begin
        nxt_class = `ODT_CL_MSX;
        uses_w    = 1'b1;
      end else if (fetch_byte1[7:1] == `ODT_MZX_HI7) begin
        nxt_class = `ODT_CL_MZX;
        uses_w    = 1'b1;
      end else if (esc_modrm[7:6] == `ODT_MOD_REG &&
                   (esc_modrm[5:3] == `ODT_TR_SIX ||
                    esc_modrm[5:3] == `ODT_TR_SEVEN)) begin
        // test register moves, register form only
        if (fetch_byte1 == `ODT_WR_TR_BYTE)
          nxt_class = `ODT_CL_WR_TR;
        else if (fetch_byte1 == `ODT_RD_TR_BYTE)
          nxt_class = `ODT_CL_RD_TR;
      end
    end else if (fetch_byte0[7:1] == `ODT_GRP_HI7) begin
      modrm     = grp_modrm;
      has_modrm = 1'b1;
      uses_w    = 1'b1;
      case (grp_modrm[5:3])
        `ODT_REG_MULT:   nxt_class = `ODT_CL_MULT;
        `ODT_REG_NEGATE: nxt_class = `ODT_CL_NEGATE;
        `ODT_REG_NOT:    nxt_class = `ODT_CL_NOT;
        default:         nxt_class = `ODT_CL_UNKNOWN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  reg  [1:0] full_opnd_w;
  reg  [1:0] nxt_opnd_w;
  reg  [1:0] nxt_imm_w;
  reg  [1:0] nxt_disp_w;
  reg  [1:0] full_disp_w;

  always @* begin
    full_opnd_w = op_size_32 ? `ODT_W_32 : `ODT_W_16;
    // w clear is byte, set is operand size
    if (!uses_w)
      nxt_opnd_w = full_opnd_w;
    else if (wide_bit)
      nxt_opnd_w = full_opnd_w;
    else
      nxt_opnd_w = `ODT_W_8;
    case (imm_form)
      `ODT_IMM_SHORT: nxt_imm_w = `ODT_W_8;
      `ODT_IMM_WORD:  nxt_imm_w = `ODT_W_16;
      `ODT_IMM_FULL:  nxt_imm_w = nxt_opnd_w;
      default:        nxt_imm_w = `ODT_W_NONE;
    endcase
    // displacement sizing from modrm and address size
    full_disp_w = addr_size_32 ? `ODT_W_32 : `ODT_W_16;
    nxt_disp_w  = `ODT_W_NONE;
    if (has_modrm) begin
      case (modrm[7:6])
        `ODT_MOD_D8:    nxt_disp_w = `ODT_W_8;
        `ODT_MOD_DFULL: nxt_disp_w = full_disp_w;
        `ODT_MOD_NODISP: begin
          // direct address form carries a full displacement alone
          if (( addr_size_32 && modrm[2:0] == `ODT_RM_D32_ONLY) ||
              (!addr_size_32 && modrm[2:0] == `ODT_RM_D16_ONLY))
            nxt_disp_w = full_disp_w;
        end
        default:        nxt_disp_w = `ODT_W_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock counts for register or cache-hit operands
  // ----------------------------------------------------------------
  reg  [`ODT_CNT_W-1:0] nxt_cycles;

  // unknown encodings still take one slot so fetch never hangs
  always @* begin
    case (nxt_class)
      `ODT_CL_MSX:   nxt_cycles = `ODT_CYC_ONE;
      `ODT_CL_MZX:   nxt_cycles = `ODT_CYC_ONE;
      `ODT_CL_MULT:  nxt_cycles = (nxt_opnd_w == `ODT_W_32) ?
                                  `ODT_CYC_MULT_D : `ODT_CYC_MULT_BW;
      `ODT_CL_NEGATE: nxt_cycles = `ODT_CYC_ONE;
      `ODT_CL_NOT:   nxt_cycles = `ODT_CYC_ONE;
      `ODT_CL_WR_TR: nxt_cycles = `ODT_CYC_WR_TR;
      `ODT_CL_RD_TR: nxt_cycles = `ODT_CYC_RD_TR;
      default:       nxt_cycles = `ODT_CYC_ONE;
    endcase
  end

  // ----------------------------------------------------------------
  // execution timing
  // ----------------------------------------------------------------
  // counts extend while memory stalls
  odt_cycle_cnt i_odt_cycle_cnt (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .load       (accept),
    .load_cnt   (nxt_cycles),
    .stall      (mem_stall),
    .busy_ff    (),
    .last_cycle (cnt_done)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // decode results hold until the next accepted instruction
  always @(posedge ref_clk) begin
    if (srst) begin
      fetch_ready_ff   <= 1'b1;
      dec_valid_ff     <= 1'b0;
      dec_class_ff     <= `ODT_CL_UNKNOWN;
      dec_illegal_ff   <= 1'b0;
      dec_opnd_w_ff    <= `ODT_W_NONE;
      dec_imm_w_ff     <= `ODT_W_NONE;
      dec_disp_w_ff    <= `ODT_W_NONE;
      dec_sign_ext_ff  <= 1'b0;
      dec_flags_mod_ff <= 1'b0;
      dec_cycles_ff    <= {`ODT_CNT_W{1'b0}};
      exec_done_ff     <= 1'b0;
    end else begin
      dec_valid_ff <= accept;
      exec_done_ff <= cnt_done;
      // ready drops on accept and returns once the count has run out
      if (accept)
        fetch_ready_ff <= 1'b0;
      else if (cnt_done)
        fetch_ready_ff <= 1'b1;
      if (accept) begin
        dec_class_ff     <= nxt_class;
        dec_illegal_ff   <= (nxt_class == `ODT_CL_UNKNOWN);
        dec_opnd_w_ff    <= nxt_opnd_w;
        dec_imm_w_ff     <= nxt_imm_w;
        dec_disp_w_ff    <= nxt_disp_w;
        dec_sign_ext_ff  <= (nxt_class == `ODT_CL_MSX);
        dec_flags_mod_ff <= (nxt_class == `ODT_CL_NEGATE) ||
                            (nxt_class == `ODT_CL_MULT);
        dec_cycles_ff    <= nxt_cycles;
      end
    end
  end

endmodule // odt_decode
`default_nettype wire

// File: pkg/odt_map.vh
/*
 * Constants of the opcode decode and timing slice: opcode bytes,
 * field values, class codes, width codes and clock counts.
 * Assumes it is included by bare name from the design files.
 */
// What this block does
// - escape then B[111w] plus modrm is sign-extend move, one clock
// - escape then B[011w] plus modrm is zero-extend move, one clock
// - group opcode, reg 100: unsigned multiply, byte/word 4, dword 10
// - group opcode, reg 011: integer negate, one clock, sets flags
// - group opcode, reg 010: bitwise complement, one clock
// - escape 26 writes test regs six/seven (10), 24 reads them (6)
// - immediate is 8, 16, or operand size 8/16/32 for full form
// - short displacement 8-bit signed, full one 16/32 by address size
`ifndef ODT_MAP_VH
`define ODT_MAP_VH

// ------------------------------------------------------------------
// opcode bytes and fields
// ------------------------------------------------------------------
`define ODT_ESC_BYTE      8'h0F
`define ODT_MSX_HI7       7'h5F
`define ODT_MZX_HI7       7'h5B
`define ODT_GRP_HI7       7'h7B
`define ODT_WR_TR_BYTE    8'h26
`define ODT_RD_TR_BYTE    8'h24
`define ODT_REG_MULT      3'h4
`define ODT_REG_NEGATE    3'h3
`define ODT_REG_NOT       3'h2
`define ODT_TR_SIX        3'h6
`define ODT_TR_SEVEN      3'h7
`define ODT_MOD_REG       2'h3
`define ODT_MOD_D8        2'h1
`define ODT_MOD_DFULL     2'h2
`define ODT_MOD_NODISP    2'h0
`define ODT_RM_D16_ONLY   3'h6
`define ODT_RM_D32_ONLY   3'h5

// ------------------------------------------------------------------
// decoded class codes
// ------------------------------------------------------------------
`define ODT_CL_UNKNOWN    3'h0
`define ODT_CL_MSX        3'h1
`define ODT_CL_MZX        3'h2
`define ODT_CL_MULT       3'h3
`define ODT_CL_NEGATE     3'h4
`define ODT_CL_NOT        3'h5
`define ODT_CL_WR_TR      3'h6
`define ODT_CL_RD_TR      3'h7

// ------------------------------------------------------------------
// width codes (operand, immediate, displacement)
// ------------------------------------------------------------------
`define ODT_W_NONE        2'h0
`define ODT_W_8           2'h1
`define ODT_W_16          2'h2
`define ODT_W_32          2'h3

// immediate forms presented by fetch
`define ODT_IMM_NONE      2'h0
`define ODT_IMM_SHORT     2'h1
`define ODT_IMM_WORD      2'h2
`define ODT_IMM_FULL      2'h3

// ------------------------------------------------------------------
// clock counts, register or cache-hit case
// ------------------------------------------------------------------
`define ODT_CNT_W         4
`define ODT_CYC_ONE       4'h1
`define ODT_CYC_MULT_BW   4'h4
`define ODT_CYC_MULT_D    4'hA
`define ODT_CYC_WR_TR     4'hA
`define ODT_CYC_RD_TR     4'h6

`endif

// File: verification/odt_decode_bench.sv
/* bench for the decode slice: scenario tasks, execution model, checker.
   assumes design, model and checker files compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module odt_decode_bench;
  logic       ref_clk, srst, fetch_valid, op_size_32, addr_size_32;
  logic [7:0] fetch_byte0, fetch_byte1, fetch_byte2;
  logic [1:0] imm_form;
  logic [3:0] stall_len;
  wire logic  mem_stall, fetch_ready_ff, dec_valid_ff, dec_illegal_ff;
  wire logic  dec_sign_ext_ff, dec_flags_mod_ff, exec_done_ff;
  wire logic [2:0] dec_class_ff;
  wire logic [1:0] dec_opnd_w_ff, dec_imm_w_ff, dec_disp_w_ff;
  wire logic [3:0] dec_cycles_ff;
  wire logic  take = fetch_valid & fetch_ready_ff;
  int         mismatches, n_checks;

  odt_decode i_odt_decode (.*);
  odt_exec_model i_odt_exec_model (.*);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one instruction: f is {op32, addr32, imm_form}; wd[6] skips widths
  task go(input logic [7:0] b0, b1, b2, input logic [3:0] f, st,
          input logic [2:0] cl, input logic [6:0] wd, input logic [3:0] cy);
    int k;
    {op_size_32, addr_size_32, imm_form} = f;
    fetch_byte0 = b0;
    fetch_byte1 = b1;
    fetch_byte2 = b2;
    stall_len = st;
    fetch_valid = 1'b1;
    @(posedge ref_clk);
    #1 fetch_valid = 1'b0;
    chk(dec_valid_ff, 8'h01);
    chk(dec_class_ff, cl);
    chk(dec_illegal_ff, cl == 3'h0);
    if (!wd[6])
      chk({dec_opnd_w_ff, dec_imm_w_ff, dec_disp_w_ff}, wd[5:0]);
    chk(dec_cycles_ff, cy);
    // count edges until done; ready must return with it
    for (k = 1; k < 40 && exec_done_ff !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 40) begin
      mismatches++;
      finish_test;
    end
    chk(8'(k - 1), 8'(cy + st));
    chk(fetch_ready_ff, 8'h01);
  endtask

  task t_moves;
    go(8'h0F, 8'hBE, 8'hC0, 4'h0, 4'h0, 3'h1, 7'h10, 4'h1);
    go(8'h0F, 8'hBF, 8'hC0, 4'h8, 4'h0, 3'h1, 7'h30, 4'h1);
    go(8'h0F, 8'hB7, 8'hC0, 4'h0, 4'h0, 3'h2, 7'h20, 4'h1);
    go(8'h0F, 8'hB6, 8'h45, 4'h0, 4'h0, 3'h2, 7'h11, 4'h1);
    $display("t_moves done");
  endtask

  task t_group;
    go(8'hF6, 8'hE0, 8'h00, 4'h0, 4'h0, 3'h3, 7'h10, 4'h4);
    go(8'hF7, 8'hE0, 8'h00, 4'h0, 4'h0, 3'h3, 7'h20, 4'h4);
    go(8'hF7, 8'hE0, 8'h00, 4'h8, 4'h0, 3'h3, 7'h30, 4'hA);
    go(8'hF7, 8'hD8, 8'h00, 4'h8, 4'h0, 3'h4, 7'h30, 4'h1);
    go(8'hF6, 8'hD0, 8'h00, 4'h0, 4'h0, 3'h5, 7'h10, 4'h1);
    $display("t_group done");
  endtask

  task t_treg;
    go(8'h0F, 8'h26, 8'hF0, 4'h0, 4'h0, 3'h6, 7'h40, 4'hA);
    go(8'h0F, 8'h24, 8'hF8, 4'h0, 4'h0, 3'h7, 7'h40, 4'h6);
    // memory form is not a test register move
    go(8'h0F, 8'h26, 8'h30, 4'h0, 4'h0, 3'h0, 7'h40, 4'h1);
    $display("t_treg done");
  endtask

  task t_fields;
    go(8'hF7, 8'hD0, 8'h00, 4'h1, 4'h0, 3'h5, 7'h24, 4'h1);
    go(8'hF7, 8'hD0, 8'h00, 4'h2, 4'h0, 3'h5, 7'h28, 4'h1);
    go(8'hF7, 8'hD0, 8'h00, 4'h3, 4'h0, 3'h5, 7'h28, 4'h1);
    go(8'hF7, 8'hD0, 8'h00, 4'hB, 4'h0, 3'h5, 7'h3C, 4'h1);
    go(8'hF6, 8'hD0, 8'h00, 4'hB, 4'h0, 3'h5, 7'h14, 4'h1);
    go(8'hF7, 8'h50, 8'h00, 4'h0, 4'h0, 3'h5, 7'h21, 4'h1);
    go(8'hF7, 8'h90, 8'h00, 4'h4, 4'h0, 3'h5, 7'h23, 4'h1);
    go(8'hF7, 8'h90, 8'h00, 4'h0, 4'h0, 3'h5, 7'h22, 4'h1);
    go(8'hF7, 8'h16, 8'h00, 4'h0, 4'h0, 3'h5, 7'h22, 4'h1);
    go(8'hF7, 8'h15, 8'h00, 4'h4, 4'h0, 3'h5, 7'h23, 4'h1);
    $display("t_fields done");
  endtask

  // a late operand stretches the count by the stalled cycles
  task t_stall;
    go(8'hF7, 8'hE0, 8'h00, 4'h8, 4'h3, 3'h3, 7'h30, 4'hA);
    go(8'hF6, 8'hD8, 8'h00, 4'h0, 4'h2, 3'h4, 7'h10, 4'h1);
    $display("t_stall done");
  endtask

  // reset in mid-count frees fetch and drops the pending count
  task t_reset;
    int k;
    {op_size_32, addr_size_32, imm_form} = 4'h8;
    {fetch_byte0, fetch_byte1, fetch_byte2} = 24'hF7E000;
    stall_len = 4'h0;
    fetch_valid = 1'b1;
    @(posedge ref_clk);
    #1 fetch_valid = 1'b0;
    srst = 1'b1;
    @(posedge ref_clk);
    #1 srst = 1'b0;
    chk(fetch_ready_ff, 8'h01);
    chk(dec_valid_ff, 8'h00);
    chk(dec_class_ff, 8'h00);
    for (k = 0; k < 12; k++) begin
      @(posedge ref_clk);
      #1 chk(exec_done_ff, 8'h00);
    end
    go(8'hF6, 8'hD0, 8'h00, 4'h0, 4'h0, 3'h5, 7'h10, 4'h1);
    $display("t_reset done");
  endtask

  initial begin
    {srst, fetch_valid, op_size_32, addr_size_32} = 4'hF;
    {fetch_byte0, fetch_byte1, fetch_byte2} = 24'h0;
    {imm_form, stall_len} = 6'h0;
    {fetch_valid, op_size_32, addr_size_32} = 3'h0;
    repeat (16) @(posedge ref_clk);
    #1;
    chk(fetch_ready_ff, 8'h01);
    chk(dec_valid_ff, 8'h00);
    srst = 1'b0;
    @(posedge ref_clk);
    #1;
    t_moves;
    t_group;
    t_treg;
    t_fields;
    t_stall;
    t_reset;
    finish_test;
  end
endmodule // odt_decode_bench

bind odt_decode odt_properties i_odt_properties (.*);
`default_nettype wire

// File: verification/odt_exec_model.sv
/* execution pipe model: raises mem_stall for a set number of
   cycles after each accepted instruction.
   assumes the bench sets stall_len before each request. */
`timescale 1ns/1ps
`default_nettype none
module odt_exec_model (
  // clock and accept seen at decode
  input  wire logic       ref_clk,
  input  wire logic       take,
  // operand delay for the next instruction
  input  wire logic [3:0] stall_len,
  output var  logic       mem_stall
);
  initial mem_stall = 1'b0;
  // late operand
  // stall starts in the cycle after accept, as a cache miss would
  always @(posedge ref_clk) begin
    if (take && stall_len != 4'h0) begin
      #1 mem_stall = 1'b1;
      repeat (stall_len) @(posedge ref_clk);
      #1 mem_stall = 1'b0;
    end
  end
endmodule // odt_exec_model
`default_nettype wire

// File: verification/odt_properties.sv
/* checker for the decode slice, port relations only.
   assumes a bind onto odt_decode from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module odt_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // fetch side
  input wire logic       fetch_valid,
  input wire logic [7:0] fetch_byte0,
  input wire logic [7:0] fetch_byte1,
  input wire logic [7:0] fetch_byte2,
  input wire logic       op_size_32,
  input wire logic [1:0] imm_form,
  input wire logic       fetch_ready_ff,
  // execution side
  input wire logic       mem_stall,
  input wire logic       dec_valid_ff,
  input wire logic [2:0] dec_class_ff,
  input wire logic [1:0] dec_opnd_w_ff,
  input wire logic [1:0] dec_imm_w_ff,
  input wire logic [1:0] dec_disp_w_ff,
  input wire logic       dec_sign_ext_ff,
  input wire logic       dec_flags_mod_ff,
  input wire logic [3:0] dec_cycles_ff,
  input wire logic       exec_done_ff
);
  // -----------------------------------------
  // request shapes
  // -----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic [2:0] g_reg = fetch_byte1[5:3];
  sequence s_take; fetch_valid && fetch_ready_ff; endsequence
  sequence s_grp; s_take ##0 fetch_byte0[7:1] == 7'h7B; endsequence
  sequence s_esc; s_take ##0 fetch_byte0 == 8'h0F; endsequence

  a_take_busy: assert property
    (s_take |=> dec_valid_ff && !fetch_ready_ff)
    else $error("accept without busy");
  a_done_ready: assert property
    (exec_done_ff |-> fetch_ready_ff)
    else $error("done without ready");
  a_one_clock: assert property
    (dec_valid_ff && dec_cycles_ff == 4'h1 && !mem_stall |=> exec_done_ff)
    else $error("one clock late");
  a_stall_hold: assert property
    (dec_valid_ff && mem_stall |=> !exec_done_ff)
    else $error("stall ignored");
  a_sign_move: assert property
    (s_esc ##0 fetch_byte1[7:1] == 7'h5F |=>
     dec_class_ff == 3'h1 && dec_sign_ext_ff && dec_cycles_ff == 4'h1)
    else $error("sign move");
  a_zero_move: assert property
    (s_esc ##0 fetch_byte1[7:1] == 7'h5B |=>
     dec_class_ff == 3'h2 && !dec_sign_ext_ff && dec_cycles_ff == 4'h1)
    else $error("zero move");
  a_mult_dword: assert property
    (s_grp ##0 g_reg == 3'h4 && fetch_byte0[0] && op_size_32 |=>
     dec_class_ff == 3'h3 && dec_cycles_ff == 4'hA)
    else $error("multiply dword");
  a_mult_short: assert property
    (s_grp ##0 g_reg == 3'h4 && !(fetch_byte0[0] && op_size_32) |=>
     dec_class_ff == 3'h3 && dec_cycles_ff == 4'h4)
    else $error("multiply byte or word");
  a_negate_flags: assert property
    (s_grp ##0 g_reg == 3'h3 |=>
     dec_class_ff == 3'h4 && dec_flags_mod_ff && dec_cycles_ff == 4'h1)
    else $error("negate");
  a_not_one: assert property
    (s_grp ##0 g_reg == 3'h2 |=>
     dec_class_ff == 3'h5 && dec_cycles_ff == 4'h1)
    else $error("complement");
  a_test_write: assert property
    (s_esc ##0 fetch_byte1 == 8'h26 && fetch_byte2[7:4] == 4'hF |=>
     dec_class_ff == 3'h6 && dec_cycles_ff == 4'hA)
    else $error("test write");
  a_test_read: assert property
    (s_esc ##0 fetch_byte1 == 8'h24 && fetch_byte2[7:4] == 4'hF |=>
     dec_class_ff == 3'h7 && dec_cycles_ff == 4'h6)
    else $error("test read");
  a_imm_short: assert property
    (s_take ##0 imm_form == 2'h1 |=> dec_imm_w_ff == 2'h1)
    else $error("short immediate");
  a_disp_short: assert property
    (s_grp ##0 fetch_byte1[7:6] == 2'h1 |=> dec_disp_w_ff == 2'h1)
    else $error("short displacement");
  a_byte_opnd: assert property
    (s_grp ##0 !fetch_byte0[0] |=> dec_opnd_w_ff == 2'h1)
    else $error("byte operand");
endmodule // odt_properties
`default_nettype wire
